// ==== shared/bowtc_regs.vh ====
// Purpose: Register map, field positions, status codes and rate constants
//          of the byte oriented two wire controller.
// Assumes: 8-bit special function register bus, system clock on clock_i.
// Notes:   Definitions only; included by bare name.
`ifndef BOWTC_REGS_VH
`define BOWTC_REGS_VH

// Register addresses on the special function register bus
`define BOWTC_ADDR_CONTROL 8'hd8
`define BOWTC_ADDR_STATUS 8'hd9
`define BOWTC_ADDR_DATA 8'hda
`define BOWTC_ADDR_OWN 8'hdb

// Control register field positions
`define BOWTC_CTL_RATE_HIGH 7
`define BOWTC_CTL_ENABLE 6
`define BOWTC_CTL_BEGIN 5
`define BOWTC_CTL_END 4
`define BOWTC_CTL_FLAG 3
`define BOWTC_CTL_ACK 2
`define BOWTC_CTL_RATE_MID 1
`define BOWTC_CTL_RATE_LOW 0

// Own address register: general call enable position
`define BOWTC_OWN_GC 0

// Reset values
`define BOWTC_RST_CONTROL 8'h00
`define BOWTC_RST_OWN 8'h00
`define BOWTC_RST_DATA 8'h00
`define BOWTC_RST_READ 8'h00

// Status codes, low three bits always zero
`define BOWTC_ST_BUS_ERR 8'h00
`define BOWTC_ST_START 8'h08
`define BOWTC_ST_RSTART 8'h10
`define BOWTC_ST_AW_ACK 8'h18
`define BOWTC_ST_AW_NACK 8'h20
`define BOWTC_ST_DT_ACK 8'h28
`define BOWTC_ST_DT_NACK 8'h30
`define BOWTC_ST_ARB_LOST 8'h38
`define BOWTC_ST_AR_ACK 8'h40
`define BOWTC_ST_AR_NACK 8'h48
`define BOWTC_ST_DR_ACK 8'h50
`define BOWTC_ST_DR_NACK 8'h58
`define BOWTC_ST_SW_OWN 8'h60
`define BOWTC_ST_SW_GC 8'h70
`define BOWTC_ST_SR_OWN_ACK 8'h80
`define BOWTC_ST_SR_OWN_NACK 8'h88
`define BOWTC_ST_SR_GC_ACK 8'h90
`define BOWTC_ST_SR_GC_NACK 8'h98
`define BOWTC_ST_SLV_END 8'ha0
`define BOWTC_ST_SR_READ 8'ha8
`define BOWTC_ST_ST_ACK 8'hb8
`define BOWTC_ST_ST_NACK 8'hc0
`define BOWTC_ST_ST_LAST 8'hc8
`define BOWTC_ST_IDLE 8'hf8

// Half SCL periods in system clocks (divisors 60,1600,40,30,240,3200,160,120)
`define BOWTC_HALF_000 12'h01e
`define BOWTC_HALF_001 12'h320
`define BOWTC_HALF_010 12'h014
`define BOWTC_HALF_011 12'h00f
`define BOWTC_HALF_100 12'h078
`define BOWTC_HALF_101 12'h640
`define BOWTC_HALF_110 12'h050
`define BOWTC_HALF_111 12'h03c

// Bit counter values of the acknowledge bit and the last data bit
`define BOWTC_ACK_BIT 4'h8
`define BOWTC_LAST_DATA_BIT 4'h7

`endif

// ==== hdl/bowtc_controller.v ====
// Purpose: Byte oriented two wire bus controller, master and slave, with
//          control, status, data and own address registers.
// Assumes: Open-drain SCL/SDA resolved outside; registers on the SFR bus.
// Notes:   Clearing the enable bit resets the bus engine, status and data; own address is kept.
`timescale 1ns/1ns
`include "bowtc_regs.vh"

// Overview of operation
// - CPU reads and writes control; hardware only sets flag, clears end request.
// - End request cleared by bus STOP and whenever unit enable is 0.
// - Unit enable 0 holds engine in reset with SCL and SDA released.
// - Begin request: START when bus free, repeated START when master.
// - End request as master generates a STOP.
// - End request as slave: no STOP, release lines, unaddressed, clear bit.
// - Master sets flag after START and each byte, also on arbitration loss.
// - Flag on own address or enabled general call with ack enable set.
// - Addressed slave sets flag after each byte and on STOP or START.
// - Flag set holds SCL low, except after arbitration loss (38H) or slave STOP/START (A0H); only software clears the flag.
// - Ack enable set: acknowledge address, general call and received bytes.
// - Ack enable clear: no acknowledge, no response to own or general call.
// - Rate codes 100..111 divide clock by 240, 3200, 160, 120.
// - Rate codes 000..011 divide clock by 60, 1600, 40, 30.
// - Slave ignores rate bits and follows the master clock.
// - Status register is read only and usable as a routine index.
// - Status code in bits 7 to 3, bits 2 to 0 read zero.
// - Master reports 08H after START and 10H after repeated START.
// - Master transmitter reports 18H after address-write acknowledged.
// - Master transmitter reports 28H after data byte acknowledged.
// - Arbitration loss in address, direction or data reports 38H.
// - Own address in bits 7 to 1; bit 0 enables general call.
// - Status F8H when nothing relevant and the flag is clear.
// - Data shifts most significant bit first, right to left.
module bowtc_controller (
   input wire clock_i,
   input wire rst_n_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire [7:0] sfr_wdata_i,
   output reg [7:0] sfr_rdata_o,
   input wire scl_i,
   input wire sda_i,
   output reg scl_o,
   output reg scl_oe_o,
   output reg sda_o,
   output reg sda_oe_o,
   output reg serial_irq_o
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RS = 5'h02;
   localparam [4:0] ST_XFER = 5'h04;
   localparam [4:0] ST_WAIT = 5'h08;
   localparam [4:0] ST_STOP = 5'h10;

   // Half SCL period for the selected rate code
   function [11:0] bowtc_half;
      input [2:0] code;
      begin
         case (code)
            3'h0: bowtc_half = `BOWTC_HALF_000;
            3'h1: bowtc_half = `BOWTC_HALF_001;
            3'h2: bowtc_half = `BOWTC_HALF_010;
            3'h3: bowtc_half = `BOWTC_HALF_011;
            3'h4: bowtc_half = `BOWTC_HALF_100;
            3'h5: bowtc_half = `BOWTC_HALF_101;
            3'h6: bowtc_half = `BOWTC_HALF_110;
            default: bowtc_half = `BOWTC_HALF_111;
         endcase
      end
   endfunction

   reg [7:0] ctl;
   reg [7:0] status;
   reg [7:0] shift;
   reg [7:0] own_addr;
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg scl_d;
   reg sda_d;
   reg [4:0] state;
   reg [1:0] step;
   reg [11:0] hcnt;
   reg [3:0] bit_cnt;
   reg master;
   reg addressed;
   reg rs_flag;
   reg addr_phase;
   reg rd_dir;
   reg tx;
   reg slv_tx;
   reg gc_sel;
   reg rose;
   reg got_ack;
   reg ack_sent;
   reg drop_after;
   reg busy;
   reg set_si_p;
   reg clr_sto_p;

   wire scl_s = scl_sync[1];
   wire sda_s = sda_sync[1];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
   wire wr_ctl = sfr_wr_i && (sfr_addr_i == `BOWTC_ADDR_CONTROL);
   wire next_en = wr_ctl ? sfr_wdata_i[`BOWTC_CTL_ENABLE] : ctl[`BOWTC_CTL_ENABLE];
   wire [2:0] rate = {ctl[`BOWTC_CTL_RATE_HIGH], ctl[`BOWTC_CTL_RATE_MID],
                      ctl[`BOWTC_CTL_RATE_LOW]};
   wire [11:0] half_m1 = bowtc_half(rate) - 12'h001;
   wire tick = (hcnt == half_m1);
   wire aa = ctl[`BOWTC_CTL_ACK];
   wire own_hit = aa && (shift[7:1] == own_addr[7:1]);
   wire gc_hit = aa && own_addr[`BOWTC_OWN_GC] && (shift == 8'h00);
   wire next_tx = master ? (addr_phase | ~rd_dir) : slv_tx;
   wire si_busy = ctl[`BOWTC_CTL_FLAG] | set_si_p;

   // Two-stage synchronisers on the bus pins, third stage for edges
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end

   // Control register; hardware set of the flag beats a software clear
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         ctl <= `BOWTC_RST_CONTROL;
         serial_irq_o <= 1'b0;
      end
      else
      begin
         if (wr_ctl)
            ctl <= sfr_wdata_i;
         if (set_si_p)
            ctl[`BOWTC_CTL_FLAG] <= 1'b1;
         if ((clr_sto_p && !wr_ctl) || !next_en)
            ctl[`BOWTC_CTL_END] <= 1'b0;
         serial_irq_o <= set_si_p | (wr_ctl ? sfr_wdata_i[`BOWTC_CTL_FLAG] :
                         ctl[`BOWTC_CTL_FLAG]);
      end
   end

   // Own address register and registered read port; open-drain levels
   always @(posedge clock_i)
   begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      if (!rst_n_i)
      begin
         own_addr <= `BOWTC_RST_OWN;
         sfr_rdata_o <= `BOWTC_RST_READ;
      end
      else
      begin
         if (sfr_wr_i && (sfr_addr_i == `BOWTC_ADDR_OWN))
            own_addr <= sfr_wdata_i;
         case (sfr_addr_i)
            `BOWTC_ADDR_CONTROL: sfr_rdata_o <= ctl;
            `BOWTC_ADDR_STATUS: sfr_rdata_o <= {status[7:3], 3'h0};
            `BOWTC_ADDR_DATA: sfr_rdata_o <= shift;
            `BOWTC_ADDR_OWN: sfr_rdata_o <= own_addr;
            default: sfr_rdata_o <= `BOWTC_RST_READ;
         endcase
      end
   end

   // Bus engine; unit enable low keeps it in reset with both lines released
   always @(posedge clock_i)
   begin
      if (!rst_n_i || !ctl[`BOWTC_CTL_ENABLE])
      begin
         state <= ST_IDLE;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         status <= `BOWTC_ST_IDLE;
         shift <= `BOWTC_RST_DATA;
         step <= 2'h0;
         hcnt <= 12'h000;
         bit_cnt <= 4'h0;
         master <= 1'b0;
         addressed <= 1'b0;
         rs_flag <= 1'b0;
         addr_phase <= 1'b0;
         rd_dir <= 1'b0;
         tx <= 1'b0;
         slv_tx <= 1'b0;
         gc_sel <= 1'b0;
         rose <= 1'b0;
         got_ack <= 1'b0;
         ack_sent <= 1'b0;
         drop_after <= 1'b0;
         busy <= 1'b0;
         set_si_p <= 1'b0;
         clr_sto_p <= 1'b0;
      end
      else
      begin
         set_si_p <= 1'b0;
         clr_sto_p <= stop_det;
         hcnt <= hcnt + 12'h001;
         if (start_det)
            busy <= 1'b1;
         else if (stop_det)
            busy <= 1'b0;
         if (sfr_wr_i && (sfr_addr_i == `BOWTC_ADDR_DATA) && state != ST_XFER)
            shift <= sfr_wdata_i;
         // STOP or START seen while addressed ends the slave transfer
         if (!master && addressed && (start_det || stop_det) &&
             (state == ST_XFER || state == ST_WAIT))
         begin
            addressed <= 1'b0;
            status <= `BOWTC_ST_SLV_END;
            set_si_p <= 1'b1;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            state <= ST_WAIT;
         end
         else
         case (state)
            ST_IDLE:
            begin
               if (ctl[`BOWTC_CTL_BEGIN] && !busy && scl_s && sda_s)
               begin
                  master <= 1'b1;
                  rs_flag <= 1'b0;
                  sda_oe_o <= 1'b1;
                  step <= 2'h2;
                  hcnt <= 12'h000;
                  state <= ST_RS;
               end
               else if (start_det)
               begin
                  addr_phase <= 1'b1;
                  tx <= 1'b0;
                  bit_cnt <= 4'h0;
                  rose <= 1'b0;
                  state <= ST_XFER;
               end
            end
            ST_RS:
            begin
               if (step == 2'h0 && tick)
               begin
                  scl_oe_o <= 1'b0;
                  hcnt <= 12'h000;
                  step <= 2'h1;
               end
               else if (step == 2'h1)
               begin
                  // Wait for SCL high so a stretching slave is honoured
                  if (!scl_s)
                     hcnt <= 12'h000;
                  else if (tick)
                  begin
                     sda_oe_o <= 1'b1;
                     hcnt <= 12'h000;
                     step <= 2'h2;
                  end
               end
               else if (step == 2'h2 && tick)
               begin
                  scl_oe_o <= 1'b1;
                  addr_phase <= 1'b1;
                  status <= rs_flag ? `BOWTC_ST_RSTART : `BOWTC_ST_START;
                  set_si_p <= 1'b1;
                  state <= ST_WAIT;
               end
            end
            ST_XFER:
            begin
               // Master SCL generation; slaves only follow the bus clock
               if (master)
               begin
                  if (scl_oe_o)
                  begin
                     if (tick)
                     begin
                        scl_oe_o <= 1'b0;
                        hcnt <= 12'h000;
                     end
                  end
                  else if (!scl_s)
                     hcnt <= 12'h000;
                  else if (tick)
                  begin
                     scl_oe_o <= 1'b1;
                     hcnt <= 12'h000;
                  end
               end
               if (scl_rise)
               begin
                  rose <= 1'b1;
                  if (bit_cnt != `BOWTC_ACK_BIT)
                     shift <= {shift[6:0], sda_s};
                  else
                     got_ack <= ~sda_s;
                  // Released a one but the line reads zero: another master won
                  if (master && tx && !sda_oe_o && !sda_s && bit_cnt != `BOWTC_ACK_BIT)
                  begin
                     master <= 1'b0;
                     scl_oe_o <= 1'b0;
                     status <= `BOWTC_ST_ARB_LOST;
                     set_si_p <= 1'b1;
                     state <= ST_WAIT;
                  end
               end
               else if (scl_fall && rose)
               begin
                  rose <= 1'b0;
                  if (bit_cnt == `BOWTC_ACK_BIT)
                  begin
                     sda_oe_o <= 1'b0;
                     scl_oe_o <= 1'b1;
                     set_si_p <= 1'b1;
                     state <= ST_WAIT;
                     if (master && addr_phase)
                     begin
                        rd_dir <= shift[0];
                        addr_phase <= 1'b0;
                        if (shift[0])
                           status <= got_ack ? `BOWTC_ST_AR_ACK : `BOWTC_ST_AR_NACK;
                        else
                           status <= got_ack ? `BOWTC_ST_AW_ACK : `BOWTC_ST_AW_NACK;
                     end
                     else if (master && tx)
                        status <= got_ack ? `BOWTC_ST_DT_ACK : `BOWTC_ST_DT_NACK;
                     else if (master)
                        status <= ack_sent ? `BOWTC_ST_DR_ACK : `BOWTC_ST_DR_NACK;
                     else if (addr_phase)
                     begin
                        addressed <= 1'b1;
                        addr_phase <= 1'b0;
                        drop_after <= 1'b0;
                        gc_sel <= ~own_hit;
                        slv_tx <= own_hit & shift[0];
                        if (own_hit)
                           status <= shift[0] ? `BOWTC_ST_SR_READ : `BOWTC_ST_SW_OWN;
                        else
                           status <= `BOWTC_ST_SW_GC;
                     end
                     else if (slv_tx)
                     begin
                        drop_after <= ~got_ack | ~aa;
                        if (!got_ack)
                           status <= `BOWTC_ST_ST_NACK;
                        else
                           status <= aa ? `BOWTC_ST_ST_ACK : `BOWTC_ST_ST_LAST;
                     end
                     else
                     begin
                        drop_after <= ~ack_sent;
                        if (gc_sel)
                           status <= ack_sent ? `BOWTC_ST_SR_GC_ACK : `BOWTC_ST_SR_GC_NACK;
                        else
                           status <= ack_sent ? `BOWTC_ST_SR_OWN_ACK : `BOWTC_ST_SR_OWN_NACK;
                     end
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt != `BOWTC_LAST_DATA_BIT)
                        sda_oe_o <= tx & ~shift[7];
                     else if (tx)
                        sda_oe_o <= 1'b0;
                     else if (!master && addr_phase)
                     begin
                        if (own_hit || gc_hit)
                        begin
                           sda_oe_o <= 1'b1;
                           ack_sent <= 1'b1;
                        end
                        else
                        begin
                           sda_oe_o <= 1'b0;
                           state <= ST_IDLE;
                        end
                     end
                     else
                     begin
                        sda_oe_o <= aa;
                        ack_sent <= aa;
                     end
                  end
               end
            end
            ST_WAIT:
            begin
               // Leave only after software cleared the flag
               if (!si_busy)
               begin
                  status <= `BOWTC_ST_IDLE;
                  hcnt <= 12'h000;
                  rose <= 1'b0;
                  bit_cnt <= 4'h0;
                  if (master && ctl[`BOWTC_CTL_END])
                  begin
                     sda_oe_o <= 1'b1;
                     step <= 2'h0;
                     state <= ST_STOP;
                  end
                  else if (master && ctl[`BOWTC_CTL_BEGIN])
                  begin
                     sda_oe_o <= 1'b0;
                     rs_flag <= 1'b1;
                     step <= 2'h0;
                     state <= ST_RS;
                  end
                  else if (!master && (ctl[`BOWTC_CTL_END] || !addressed || drop_after))
                  begin
                     addressed <= 1'b0;
                     scl_oe_o <= 1'b0;
                     sda_oe_o <= 1'b0;
                     if (ctl[`BOWTC_CTL_END])
                        clr_sto_p <= 1'b1;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     tx <= next_tx;
                     sda_oe_o <= next_tx & ~shift[7];
                     if (!master)
                        scl_oe_o <= 1'b0;
                     state <= ST_XFER;
                  end
               end
            end
            ST_STOP:
            begin
               if (step == 2'h0 && tick)
               begin
                  scl_oe_o <= 1'b0;
                  hcnt <= 12'h000;
                  step <= 2'h1;
               end
               else if (step == 2'h1)
               begin
                  if (!scl_s)
                     hcnt <= 12'h000;
                  else if (tick)
                  begin
                     sda_oe_o <= 1'b0;
                     master <= 1'b0;
                     clr_sto_p <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule // bowtc_controller

// ==== testbench/bowtc_controller_asserts.sv ====
// Purpose: Port level checks of the two wire controller
// Assumes: Bound into bowtc_controller, single clock domain
// Notes:   Enable bit is shadowed from bus writes
`timescale 1ns/1ns
module bowtc_checker (
   input wire clock_i,
   input wire rst_n_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire [7:0] sfr_wdata_i,
   input wire [7:0] sfr_rdata_o,
   input wire scl_i,
   input wire sda_i,
   input wire scl_o,
   input wire scl_oe_o,
   input wire sda_o,
   input wire sda_oe_o,
   input wire serial_irq_o
);
   reg en_q;
   // Shadow of the unit enable bit
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
         en_q <= 1'b0;
      else if (sfr_wr_i && sfr_addr_i == 8'hd8)
         en_q <= sfr_wdata_i[6];
   end
   default clocking dck @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Lines are only ever pulled low
   chk_open_drain: assert property (!scl_o && !sda_o)
      else $error("line driven high");
   chk_off_released: assert property (!en_q [*4] |-> !scl_oe_o && !sda_oe_o)
      else $error("line held while disabled");
   chk_code_step: assert property ($past(sfr_addr_i) == 8'hd9 |-> sfr_rdata_o[2:0] == 3'h0)
      else $error("status low bits not zero");
   chk_ctrl_readback: assert property ((sfr_wr_i && sfr_addr_i == 8'hd8) ##1
      (!sfr_wr_i && sfr_addr_i == 8'hd8) |=> (sfr_rdata_o & 8'he7) == ($past(sfr_wdata_i, 2) & 8'he7))
      else $error("control readback differs");
   chk_irq_mirror: assert property ($past(sfr_addr_i) == 8'hd8 |-> sfr_rdata_o[3] == $past(serial_irq_o))
      else $error("interrupt differs from flag");
   chk_flag_holds_scl: assert property (en_q && !sfr_wr_i && serial_irq_o && scl_oe_o
      |=> scl_oe_o || !serial_irq_o)
      else $error("clock released while flag set");
   chk_end_off: assert property ((!en_q && !sfr_wr_i) [*3] ##0 $past(sfr_addr_i) == 8'hd8
      |-> !sfr_rdata_o[4])
      else $error("end request kept while disabled");
   chk_begin_start: assert property (sfr_wr_i && sfr_addr_i == 8'hd8 && sfr_wdata_i[6:5] == 2'b11
      && !serial_irq_o && scl_i && sda_i && !sda_oe_o |-> ##[1:1000] sda_oe_o)
      else $error("no start on free bus");
endmodule // bowtc_checker

bind bowtc_controller bowtc_checker u_bowtc_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .serial_irq_o(serial_irq_o));

// ==== testbench/bowtc_bus_partner.sv ====
// Purpose: Behavioural write target on the two wire bus
// Assumes: Lines resolved by the bench with pull-ups
// Notes:   Acks own address and data; stretching slows the master down
`timescale 1ns/1ns
module bowtc_bus_partner #(
   parameter [6:0] DEV_ADDR = 7'h2a
) (
   input wire scl_i,
   input wire sda_i,
   input wire nack_i,
   input wire stretch_i,
   output reg sda_low_o = 1'b0,
   output reg scl_low_o = 1'b0,
   output reg [7:0] last_byte_o = 8'h00,
   output reg [7:0] stop_cnt_o = 8'h00
);
   integer bit_n = 0;
   integer byte_n = 0;
   reg [7:0] sh = 8'h00;
   // Start condition restarts framing
   always @(negedge sda_i)
   begin
      if (scl_i)
      begin
         bit_n = 0;
         byte_n = 0;
      end
   end
   // Stop conditions counted for the bench
   always @(posedge sda_i)
   begin
      if (scl_i)
         stop_cnt_o = stop_cnt_o + 8'h01;
   end
   // Sample on rising clock, first bit is the MSB
   always @(posedge scl_i)
   begin
      if (bit_n < 8)
         sh = {sh[6:0], sda_i};
      bit_n = bit_n + 1;
   end
   // Ack slot after eight bits; optional low phase stretch
   always @(negedge scl_i)
   begin
      sda_low_o = (bit_n == 8) && !nack_i && (byte_n > 0 || sh[7:1] == DEV_ADDR);
      if (bit_n == 8)
         last_byte_o = sh;
      if (bit_n == 9)
      begin
         bit_n = 0;
         byte_n = byte_n + 1;
      end
      if (stretch_i)
      begin
         scl_low_o = 1'b1;
         #800 scl_low_o = 1'b0;
      end
   end
endmodule // bowtc_bus_partner

// ==== testbench/tb_bowtc_controller.sv ====
// Purpose: Self-checking bench of the two wire controller
// Assumes: 25 MHz clock, partner answers at address 2a
// Notes:   Master transmit, rate sweep, arbitration loss, registers
`timescale 1ns/1ns
module tb_bowtc_controller;
   localparam [95:0] DIVS = {12'h078, 12'h0a0, 12'hc80, 12'h0f0, 12'h01e, 12'h028, 12'h640, 12'h03c};
   reg clock_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg [7:0] sfr_addr_i = 8'h00;
   reg sfr_wr_i = 1'b0;
   reg [7:0] sfr_wdata_i = 8'h00;
   reg nack = 1'b0;
   reg stretch = 1'b0;
   reg tb_sda_low = 1'b0;
   reg [7:0] v;
   reg [7:0] s0;
   integer miscompares = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer per;
   integer c;
   time t0;
   wire [7:0] sfr_rdata_o;
   wire scl_oe_o, sda_oe_o, serial_irq_o, p_sda_low, p_scl_low;
   wire [7:0] p_byte, p_stops;
   wire scl_w = !(scl_oe_o || p_scl_low);
   wire sda_w = !(sda_oe_o || p_sda_low || tb_sda_low);
   bowtc_controller u_bowtc_controller (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(), .scl_oe_o(scl_oe_o),
      .sda_o(), .sda_oe_o(sda_oe_o), .serial_irq_o(serial_irq_o));
   bowtc_bus_partner u_bowtc_bus_partner (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
      .stretch_i(stretch), .sda_low_o(p_sda_low), .scl_low_o(p_scl_low), .last_byte_o(p_byte),
      .stop_cnt_o(p_stops));
   // Clock and hang guard, ceiling well above the slow rate codes
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i)
   begin
      cycles = cycles + 1;
      if (cycles == 90000)
      begin
         miscompares = miscompares + 1;
         conclude;
      end
   end
   function [7:0] ctl(input [2:0] r);
      ctl = {r[2], 5'b10001, r[1:0]};
   endfunction
   task check(input [11:0] seen, input [11:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   // Bus cycles: write holds strobe one edge, read samples after the edge
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
   end
   endtask
   task rd(input [7:0] a);
   begin
      @(posedge clock_i);
      sfr_addr_i <= a;
      @(posedge clock_i);
      #1 v = sfr_rdata_o;
   end
   endtask
   task wait_irq;
   integer n;
   begin
      n = 0;
      // Look after the edge, so a flag just cleared is not seen as still set
      #1;
      while (serial_irq_o !== 1'b1 && n < 40000)
      begin
         @(posedge clock_i);
         #1 n = n + 1;
      end
      check({11'h000, serial_irq_o}, 12'h001);
   end
   endtask
   task start(input [2:0] r);
   begin
      wr(8'hd8, ctl(r) | 8'h20);
      wait_irq;
      rd(8'hd9);
   end
   endtask
   // Load data, clear the flag, wait for the byte to finish
   task send(input [2:0] r, input [7:0] d);
   begin
      wr(8'hda, d);
      wr(8'hd8, ctl(r));
      wait_irq;
      rd(8'hd9);
   end
   endtask
   task stop(input [2:0] r);
   integer n;
   begin
      s0 = p_stops;
      wr(8'hd8, ctl(r) | 8'h10);
      n = 0;
      while (p_stops === s0 && n < 20000)
      begin
         @(posedge clock_i);
         n = n + 1;
      end
      repeat (4) @(posedge clock_i);
      check(p_stops - s0, 12'h001);
      rd(8'hd8);
      check(v & 8'h10, 12'h000);
      rd(8'hd9);
      check(v, 12'h0f8);
   end
   endtask
   task t_regs;
   begin
      rd(8'hd8);
      check(v, 12'h000);
      rd(8'hd9);
      check(v, 12'h0f8);
      wr(8'hd8, 8'h87);
      rd(8'hd8);
      check(v, 12'h087);
      wr(8'hd8, 8'h10);
      rd(8'hd8);
      check(v, 12'h000);
      wr(8'hd9, 8'h55);
      rd(8'hd9);
      check(v, 12'h0f8);
      wr(8'hdb, 8'ha5);
      rd(8'hdb);
      check(v, 12'h0a5);
      check({scl_oe_o, sda_oe_o}, 12'h000);
   end
   endtask
   // Slow partner: ack, data, nack, repeated start, wrong address
   task t_master;
   begin
      stretch <= 1'b1;
      start(3'h3);
      check(v, 12'h008);
      send(3'h3, 8'h54);
      check(v, 12'h018);
      send(3'h3, 8'hc3);
      check(v, 12'h028);
      check(p_byte, 12'h0c3);
      repeat (50) @(posedge clock_i);
      check({scl_w, scl_oe_o}, 12'h001);
      nack <= 1'b1;
      send(3'h3, 8'h5a);
      check(v, 12'h030);
      nack <= 1'b0;
      start(3'h3);
      check(v, 12'h010);
      send(3'h3, 8'h2a);
      check(v, 12'h020);
      stop(3'h3);
      stretch <= 1'b0;
   end
   endtask
   // Clock period per rate code, sync delay allows a few extra cycles
   task t_rates;
   reg [11:0] d;
   begin
      for (c = 0; c < 8; c = c + 1)
      begin
         d = DIVS[c * 12 +: 12];
         start(c[2:0]);
         check(v, 12'h008);
         wr(8'hda, 8'h54);
         wr(8'hd8, ctl(c[2:0]));
         @(posedge scl_w);
         t0 = $time;
         @(posedge scl_w);
         per = ($time - t0) / 40;
         check((per >= d && per <= d + 4) ? d : per[11:0], d);
         wait_irq;
         stop(c[2:0]);
      end
   end
   endtask
   task t_arb;
   begin
      start(3'h3);
      check(v, 12'h008);
      tb_sda_low <= 1'b1;
      send(3'h3, 8'hff);
      check(v, 12'h038);
      tb_sda_low <= 1'b0;
      wr(8'hd8, 8'h00);
      repeat (4) @(posedge clock_i);
      check({scl_oe_o, sda_oe_o}, 12'h000);
   end
   endtask
   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   // Reset for ten clocks, then the scenarios
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_master;
      t_rates;
      t_arb;
      conclude;
   end
endmodule // tb_bowtc_controller
